/* design/jlm_exec.sv */
// execute unit for register jump, displacement loads and multiply-accumulate
// Functional notes
// - register jump takes target from src_reg_b
// - one delay slot executes before redirect
// - address is src_reg_a plus sign-extended immediate
// - signed byte load sign-extends bit 7
// - unsigned byte load zero-extends
// - signed half load sign-extends bit 15
// - unsigned half load zero-extends
// - signed word load sign-extends bit 31
// - unsigned word load clears upper word
// - double load moves whole 64-bit value
// - memory faults reported; alignment except byte
// - register accumulate writes no destination register
// - signed product truncated to 32, accumulated
// - immediate accumulate uses immediate times source
// - read-and-clear waits, returns, then zeroes
`timescale 1ns/1ps
module jlm_exec
    import jlm_pkg::*;
#(
    parameter logic [5:0] OPC_LOAD_DOUBLE = OPC_LOAD_DOUBLE_DFLT,
    parameter logic [5:0] OPC_ACC_READ = OPC_ACC_READ_DFLT
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // instruction issue
    input wire logic insn_valid,
    input wire jlm_insn_t insn,
    input wire logic [XLEN-1:0] src_reg_a,
    input wire logic [XLEN-1:0] src_reg_b,
    output logic insn_ready,
    // control transfer
    output logic redirect_valid,
    output logic [XLEN-1:0] redirect_pc,
    // data memory
    output logic mem_req_valid,
    output logic [XLEN-1:0] mem_req_addr,
    output jlm_size_t mem_req_size,
    input wire logic mem_rsp_valid,
    input wire logic [XLEN-1:0] mem_rsp_data,
    input wire jlm_fault_t mem_rsp_fault,
    // register writeback
    output logic wb_valid,
    output logic [REG_IDX_W-1:0] wb_reg,
    output logic [XLEN-1:0] wb_data,
    // exceptions
    output logic exc_valid,
    output jlm_exc_t exc_cause,
    output logic [XLEN-1:0] effective_addr,
    // accumulator
    output logic [31:0] accum_upper_half,
    output logic [31:0] accum_lower_half
);
    typedef enum logic {ST_IDLE, ST_LOAD} jlm_state_t;

    function automatic logic [XLEN-1:0] sext16(input logic [IMM_W-1:0] v);
        sext16 = {{(XLEN-IMM_W){v[IMM_W-1]}}, v};
    endfunction : sext16

    function automatic logic is_load(input logic [5:0] opc, input logic [5:0] opc_dbl);
        is_load = (opc == OPC_LOAD_BYTE_S) || (opc == OPC_LOAD_BYTE_Z) ||
                  (opc == OPC_LOAD_HALF_S) || (opc == OPC_LOAD_HALF_Z) ||
                  (opc == OPC_LOAD_WORD_S) || (opc == OPC_LOAD_WORD_Z) ||
                  (opc == opc_dbl);
    endfunction : is_load

    function automatic jlm_size_t load_size(input logic [5:0] opc);
        case (opc)
            OPC_LOAD_BYTE_S, OPC_LOAD_BYTE_Z: load_size = SZ_BYTE;
            OPC_LOAD_HALF_S, OPC_LOAD_HALF_Z: load_size = SZ_HALF;
            OPC_LOAD_WORD_S, OPC_LOAD_WORD_Z: load_size = SZ_WORD;
            default: load_size = SZ_DOUBLE;
        endcase
    endfunction : load_size

    function automatic logic misaligned(input jlm_size_t sz, input logic [2:0] a);
        case (sz)
            SZ_HALF: misaligned = a[0];
            SZ_WORD: misaligned = |a[1:0];
            SZ_DOUBLE: misaligned = |a[2:0];
            default: misaligned = 1'b0;
        endcase
    endfunction : misaligned

    function automatic logic [XLEN-1:0] load_extend(input logic [5:0] opc,
                                                    input logic [XLEN-1:0] d);
        case (opc)
            OPC_LOAD_BYTE_S: load_extend = {{56{d[7]}}, d[7:0]};
            OPC_LOAD_BYTE_Z: load_extend = {56'h0, d[7:0]};
            OPC_LOAD_HALF_S: load_extend = {{48{d[15]}}, d[15:0]};
            OPC_LOAD_HALF_Z: load_extend = {48'h0, d[15:0]};
            OPC_LOAD_WORD_S: load_extend = {{32{d[31]}}, d[31:0]};
            OPC_LOAD_WORD_Z: load_extend = {32'h0, d[31:0]};
            default: load_extend = d;
        endcase
    endfunction : load_extend

    jlm_state_t st_q, st_d;
    logic jr_pend_q, jr_pend_d;
    logic [XLEN-1:0] jr_tgt_q, jr_tgt_d;
    logic redir_q, redir_d;
    logic [XLEN-1:0] redir_pc_q, redir_pc_d;
    logic [XLEN-1:0] addr_q, addr_d;
    jlm_size_t size_q, size_d;
    logic [5:0] ld_opc_q, ld_opc_d;
    logic [REG_IDX_W-1:0] rd_q, rd_d;
    logic wb_v_q, wb_v_d;
    logic [XLEN-1:0] wb_data_q, wb_data_d;
    logic exc_v_q, exc_v_d;
    jlm_exc_t exc_q, exc_d;
    logic [XLEN-1:0] acc_q, acc_d;
    logic mac_v_q, mac_v_d;
    logic [XLEN-1:0] mac_add_q, mac_add_d;
    logic issue_fire;
    logic [XLEN-1:0] ea;
    logic [63:0] prod_rr;
    logic [63:0] prod_ri;
    logic [31:0] mac_imm_x;

    // read-and-clear stalls while an accumulate is in flight
    assign insn_ready = (st_q == ST_IDLE) && !((insn.opc == OPC_ACC_READ) && mac_v_q);
    assign issue_fire = insn_valid && insn_ready;
    assign ea = src_reg_a + sext16(insn.imm);
    // low 32 bits of the product are the same signed or unsigned
    assign prod_rr = src_reg_a[31:0] * src_reg_b[31:0];
    assign mac_imm_x = {{16{insn.rd[4]}}, insn.rd, insn.imm[10:0]};
    assign prod_ri = src_reg_a[31:0] * mac_imm_x;

    always_comb begin
        st_d = st_q;
        jr_pend_d = jr_pend_q;
        jr_tgt_d = jr_tgt_q;
        redir_d = 1'b0;
        redir_pc_d = redir_pc_q;
        addr_d = addr_q;
        size_d = size_q;
        ld_opc_d = ld_opc_q;
        rd_d = rd_q;
        wb_v_d = 1'b0;
        wb_data_d = wb_data_q;
        exc_v_d = 1'b0;
        exc_d = exc_q;
        mac_v_d = 1'b0;
        mac_add_d = mac_add_q;
        acc_d = acc_q;
        if (mac_v_q) begin
            acc_d = acc_q + mac_add_q;
        end
        case (st_q)
            ST_IDLE: begin
                if (issue_fire) begin
                    // delay slot has issued, now redirect
                    if (jr_pend_q) begin
                        redir_d = 1'b1;
                        redir_pc_d = jr_tgt_q;
                        jr_pend_d = 1'b0;
                    end
                    if (insn.opc == OPC_JUMP_REG) begin
                        jr_pend_d = 1'b1;
                        jr_tgt_d = src_reg_b;
                    end else if (is_load(insn.opc, OPC_LOAD_DOUBLE)) begin
                        addr_d = ea;
                        size_d = load_size(insn.opc);
                        ld_opc_d = insn.opc;
                        rd_d = insn.rd;
                        if (misaligned(load_size(insn.opc), ea[2:0])) begin
                            exc_v_d = 1'b1;
                            exc_d = '{align: 1'b1, default: 1'b0};
                        end else begin
                            st_d = ST_LOAD;
                        end
                    end else if ((insn.opc == OPC_MAC_REG) && (insn.imm[3:0] == MINOR_MAC)) begin
                        mac_v_d = 1'b1;
                        mac_add_d = {{32{prod_rr[31]}}, prod_rr[31:0]};
                    end else if (insn.opc == OPC_MAC_IMM) begin
                        mac_v_d = 1'b1;
                        mac_add_d = {{32{prod_ri[31]}}, prod_ri[31:0]};
                    end else if (insn.opc == OPC_ACC_READ) begin
                        wb_v_d = 1'b1;
                        rd_d = insn.rd;
                        wb_data_d = acc_q;
                        acc_d = ACC_RESET;
                    end
                end
            end
            ST_LOAD: begin
                if (mem_rsp_valid) begin
                    st_d = ST_IDLE;
                    if (|mem_rsp_fault) begin
                        exc_v_d = 1'b1;
                        exc_d = '{align: 1'b0, tlb_miss: mem_rsp_fault.tlb_miss,
                                  page_fault: mem_rsp_fault.page_fault,
                                  bus_err: mem_rsp_fault.bus_err};
                    end else begin
                        wb_v_d = 1'b1;
                        wb_data_d = load_extend(ld_opc_q, mem_rsp_data);
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            jr_pend_q <= 1'b0;
            jr_tgt_q <= DATA_RESET;
            redir_q <= 1'b0;
            redir_pc_q <= DATA_RESET;
            addr_q <= DATA_RESET;
            size_q <= SZ_BYTE;
            ld_opc_q <= 6'h0;
            rd_q <= 5'h0;
            wb_v_q <= 1'b0;
            wb_data_q <= DATA_RESET;
            exc_v_q <= 1'b0;
            exc_q <= '0;
            acc_q <= ACC_RESET;
            mac_v_q <= 1'b0;
            mac_add_q <= DATA_RESET;
        end else begin
            st_q <= st_d;
            jr_pend_q <= jr_pend_d;
            jr_tgt_q <= jr_tgt_d;
            redir_q <= redir_d;
            redir_pc_q <= redir_pc_d;
            addr_q <= addr_d;
            size_q <= size_d;
            ld_opc_q <= ld_opc_d;
            rd_q <= rd_d;
            wb_v_q <= wb_v_d;
            wb_data_q <= wb_data_d;
            exc_v_q <= exc_v_d;
            exc_q <= exc_d;
            acc_q <= acc_d;
            mac_v_q <= mac_v_d;
            mac_add_q <= mac_add_d;
        end
    end

    assign redirect_valid = redir_q;
    assign redirect_pc = redir_pc_q;
    assign mem_req_valid = (st_q == ST_LOAD);
    assign mem_req_addr = addr_q;
    assign mem_req_size = size_q;
    assign wb_valid = wb_v_q;
    assign wb_reg = rd_q;
    assign wb_data = wb_data_q;
    assign exc_valid = exc_v_q;
    assign exc_cause = exc_q;
    assign effective_addr = addr_q;
    assign accum_upper_half = acc_q[63:32];
    assign accum_lower_half = acc_q[31:0];

    // checks
    a_jr_target: assert property (@(posedge core_clk) disable iff (!rstn)
        (issue_fire && insn.opc == OPC_JUMP_REG) |=> jr_tgt_q == $past(src_reg_b))
        else $error("jump target not taken from src_reg_b");
    a_delay_slot: assert property (@(posedge core_clk) disable iff (!rstn)
        redirect_valid |-> $past(issue_fire) && $past(jr_pend_q))
        else $error("redirect without a delay slot issue");
    a_ea_form: assert property (@(posedge core_clk) disable iff (!rstn)
        (issue_fire && is_load(insn.opc, OPC_LOAD_DOUBLE))
        |=> mem_req_addr == $past(src_reg_a) + sext16($past(insn.imm)))
        else $error("effective address wrong");
    a_byte_sign: assert property (@(posedge core_clk) disable iff (!rstn)
        (wb_valid && $past(st_q == ST_LOAD) && ld_opc_q == OPC_LOAD_BYTE_S)
        |-> wb_data[63:8] == {56{wb_data[7]}})
        else $error("signed byte not extended");
    a_byte_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        (wb_valid && $past(st_q == ST_LOAD) && ld_opc_q == OPC_LOAD_BYTE_Z)
        |-> wb_data[63:8] == 56'h0)
        else $error("unsigned byte not cleared");
    a_half_sign: assert property (@(posedge core_clk) disable iff (!rstn)
        (wb_valid && $past(st_q == ST_LOAD) && ld_opc_q == OPC_LOAD_HALF_S)
        |-> wb_data[63:16] == {48{wb_data[15]}})
        else $error("signed half not extended");
    a_half_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        (wb_valid && $past(st_q == ST_LOAD) && ld_opc_q == OPC_LOAD_HALF_Z)
        |-> wb_data[63:16] == 48'h0)
        else $error("unsigned half not cleared");
    a_word_sign: assert property (@(posedge core_clk) disable iff (!rstn)
        (wb_valid && $past(st_q == ST_LOAD) && ld_opc_q == OPC_LOAD_WORD_S)
        |-> wb_data == {{32{$past(mem_rsp_data[31])}}, $past(mem_rsp_data[31:0])})
        else $error("signed word wrong");
    a_word_zero: assert property (@(posedge core_clk) disable iff (!rstn)
        (wb_valid && $past(st_q == ST_LOAD) && ld_opc_q == OPC_LOAD_WORD_Z)
        |-> wb_data == {32'h0, $past(mem_rsp_data[31:0])})
        else $error("unsigned word wrong");
    a_double_full: assert property (@(posedge core_clk) disable iff (!rstn)
        (wb_valid && $past(st_q == ST_LOAD) && ld_opc_q == OPC_LOAD_DOUBLE)
        |-> wb_data == $past(mem_rsp_data))
        else $error("double load not full width");
    a_byte_align: assert property (@(posedge core_clk) disable iff (!rstn)
        (exc_valid && exc_cause.align) |-> mem_req_size != SZ_BYTE && !$past(mem_req_valid))
        else $error("alignment raised on byte or after access");
    a_fault_nowb: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_q == ST_LOAD && mem_rsp_valid && |mem_rsp_fault) |=> exc_valid && !wb_valid)
        else $error("faulting load wrote back");
    a_mac_nowb: assert property (@(posedge core_clk) disable iff (!rstn)
        (issue_fire && (insn.opc == OPC_MAC_REG || insn.opc == OPC_MAC_IMM)) |=> !wb_valid)
        else $error("accumulate wrote a register");
    a_mac_wrap: assert property (@(posedge core_clk) disable iff (!rstn)
        (mac_v_q && !$past(issue_fire && insn.opc == OPC_ACC_READ))
        |=> acc_q == $past(acc_q) + $past(mac_add_q))
        else $error("accumulator sum wrong");
    a_mac_trunc: assert property (@(posedge core_clk) disable iff (!rstn)
        (issue_fire && insn.opc == OPC_MAC_REG && insn.imm[3:0] == MINOR_MAC)
        |=> mac_v_q ##1 acc_q == $past(acc_q) + {{32{$past(mac_add_q[31])}}, $past(mac_add_q[31:0])})
        else $error("product not truncated and accumulated");
    a_read_clear: assert property (@(posedge core_clk) disable iff (!rstn)
        (issue_fire && insn.opc == OPC_ACC_READ)
        |-> !mac_v_q ##1 (wb_valid && wb_data == $past(acc_q) && acc_q == 64'h0))
        else $error("read and clear wrong");
    c_jump: cover property (@(posedge core_clk) disable iff (!rstn) redirect_valid);
    c_load_ok: cover property (@(posedge core_clk) disable iff (!rstn)
        mem_req_valid ##1 wb_valid);
    c_load_fault: cover property (@(posedge core_clk) disable iff (!rstn)
        exc_valid && !exc_cause.align);
    c_mac_read: cover property (@(posedge core_clk) disable iff (!rstn)
        mac_v_q ##1 (issue_fire && insn.opc == OPC_ACC_READ));
endmodule : jlm_exec

/* design/jlm_pkg.sv */
// shared constants, types and instruction layout for the jump, load and accumulate slice
package jlm_pkg;
    localparam int XLEN = 64;
    localparam int REG_IDX_W = 5;
    localparam int IMM_W = 16;
    localparam int PROD_W = 32;

    // primary opcodes, plus the minor opcode of register accumulate
    localparam logic [5:0] OPC_JUMP_REG = 6'h11;
    localparam logic [5:0] OPC_LOAD_BYTE_S = 6'h24;
    localparam logic [5:0] OPC_LOAD_BYTE_Z = 6'h23;
    localparam logic [5:0] OPC_LOAD_HALF_S = 6'h26;
    localparam logic [5:0] OPC_LOAD_HALF_Z = 6'h25;
    localparam logic [5:0] OPC_LOAD_WORD_S = 6'h22;
    localparam logic [5:0] OPC_LOAD_WORD_Z = 6'h21;
    localparam logic [5:0] OPC_MAC_REG = 6'h31;
    localparam logic [5:0] OPC_MAC_IMM = 6'h13;
    localparam logic [3:0] MINOR_MAC = 4'h1;
    localparam logic [5:0] OPC_LOAD_DOUBLE_DFLT = 6'h20;
    localparam logic [5:0] OPC_ACC_READ_DFLT = 6'h3e;

    // reset values
    localparam logic [XLEN-1:0] ACC_RESET = 64'h0;
    localparam logic [XLEN-1:0] DATA_RESET = 64'h0;

    // instruction word: rb sits in imm[15:11], minor opcode in imm[3:0]
    typedef struct packed {
        logic [5:0] opc;
        logic [4:0] rd;
        logic [4:0] ra;
        logic [15:0] imm;
    } jlm_insn_t;

    typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE} jlm_size_t;

    typedef struct packed {
        logic tlb_miss;
        logic page_fault;
        logic bus_err;
    } jlm_fault_t;

    typedef struct packed {
        logic align;
        logic tlb_miss;
        logic page_fault;
        logic bus_err;
    } jlm_exc_t;
endpackage : jlm_pkg

/* test/jlm_mem_model.sv */
// data memory partner model answering load requests
`timescale 1ns/1ps
module jlm_mem_model
    import jlm_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // request side
    input wire logic mem_req_valid,
    input wire logic [XLEN-1:0] mem_req_addr,
    // response side
    output logic mem_rsp_valid,
    output logic [XLEN-1:0] mem_rsp_data,
    output jlm_fault_t mem_rsp_fault,
    // bench control
    input wire jlm_fault_t fault_in,
    input wire logic [1:0] dly_in
);
    logic busy;
    logic [1:0] cnt;
    initial begin
        {mem_rsp_valid, busy, cnt} = '0;
        mem_rsp_data = '0;
        mem_rsp_fault = '0;
    end
    always @(negedge core_clk) begin
        if (!rstn || mem_rsp_valid) begin
            // released lines show the inverse of the last value
            mem_rsp_valid <= 1'b0;
            mem_rsp_data <= ~mem_rsp_data;
            mem_rsp_fault <= ~mem_rsp_fault;
            busy <= 1'b0;
        end else if (mem_req_valid && !busy) begin
            busy <= 1'b1;
            cnt <= dly_in;
        end else if (busy && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else if (busy) begin
            mem_rsp_valid <= 1'b1;
            mem_rsp_fault <= fault_in;
            mem_rsp_data <= {~mem_req_addr[31:0], mem_req_addr[31:0] ^ 32'h5a96c3e1};
        end
    end
endmodule : jlm_mem_model

/* test/tb_top.sv */
// self-checking bench for the jump, load and accumulate unit
`timescale 1ns/1ps
module tb_top;
    import jlm_pkg::*;
    logic core_clk, rstn, insn_valid, insn_ready, redirect_valid, mem_req_valid, mem_rsp_valid;
    logic wb_valid, exc_valid;
    jlm_insn_t insn;
    logic [XLEN-1:0] src_reg_a, src_reg_b, redirect_pc, mem_req_addr, mem_rsp_data;
    logic [XLEN-1:0] wb_data, effective_addr, last_rsp, exp_acc, t, addr;
    logic [REG_IDX_W-1:0] wb_reg;
    logic [31:0] accum_upper_half, accum_lower_half;
    jlm_size_t mem_req_size;
    jlm_fault_t mem_rsp_fault, fault_in;
    jlm_exc_t exc_cause;
    logic [1:0] dly_in;
    logic [5:0] ops [7];
    int mismatches, n_checks, wb_cnt, exc_cnt, rd_cnt, r0, w0;
    integer seed;

    jlm_exec uut (.core_clk(core_clk), .rstn(rstn), .insn_valid(insn_valid), .insn(insn),
        .src_reg_a(src_reg_a), .src_reg_b(src_reg_b), .insn_ready(insn_ready),
        .redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
        .mem_req_valid(mem_req_valid), .mem_req_addr(mem_req_addr), .mem_req_size(mem_req_size),
        .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
        .mem_rsp_fault(mem_rsp_fault), .wb_valid(wb_valid), .wb_reg(wb_reg), .wb_data(wb_data),
        .exc_valid(exc_valid), .exc_cause(exc_cause), .effective_addr(effective_addr),
        .accum_upper_half(accum_upper_half), .accum_lower_half(accum_lower_half));
    jlm_mem_model mem (.core_clk(core_clk), .rstn(rstn), .mem_req_valid(mem_req_valid),
        .mem_req_addr(mem_req_addr), .mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data),
        .mem_rsp_fault(mem_rsp_fault), .fault_in(fault_in), .dly_in(dly_in));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // pulse counters sampled once outputs settle
    always @(posedge core_clk) begin
        #1;
        if (mem_rsp_valid === 1'b1) last_rsp = mem_rsp_data;
        if (wb_valid === 1'b1) wb_cnt++;
        if (exc_valid === 1'b1) exc_cnt++;
        if (redirect_valid === 1'b1) rd_cnt++;
    end

    function automatic logic [XLEN-1:0] sx(logic [15:0] i);
        return {{48{i[15]}}, i};
    endfunction : sx
    function automatic logic [XLEN-1:0] ext_ld(logic [5:0] o, logic [XLEN-1:0] d);
        case (o)
            OPC_LOAD_BYTE_S: return {{56{d[7]}}, d[7:0]};
            OPC_LOAD_BYTE_Z: return {56'h0, d[7:0]};
            OPC_LOAD_HALF_S: return {{48{d[15]}}, d[15:0]};
            OPC_LOAD_HALF_Z: return {48'h0, d[15:0]};
            OPC_LOAD_WORD_S: return {{32{d[31]}}, d[31:0]};
            OPC_LOAD_WORD_Z: return {32'h0, d[31:0]};
            default: return d;
        endcase
    endfunction : ext_ld
    function automatic logic [1:0] sz(logic [5:0] o);
        case (o)
            OPC_LOAD_BYTE_S, OPC_LOAD_BYTE_Z: return 2'h0;
            OPC_LOAD_HALF_S, OPC_LOAD_HALF_Z: return 2'h1;
            OPC_LOAD_WORD_S, OPC_LOAD_WORD_Z: return 2'h2;
            default: return 2'h3;
        endcase
    endfunction : sz
    function automatic logic [XLEN-1:0] mac_val(logic [XLEN-1:0] a, logic [XLEN-1:0] b);
        logic [31:0] p;
        p = a[31:0] * b[31:0];
        return {{32{p[31]}}, p};
    endfunction : mac_val

    task automatic chk(input bit ok, input string msg);
        n_checks++;
        if (!ok) begin
            mismatches++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic issue(input logic [31:0] i, input logic [XLEN-1:0] a, input logic [XLEN-1:0] b);
        int n;
        bit ok;
        n = 0;
        ok = 1'b0;
        insn_valid = 1'b1;
        insn = jlm_insn_t'(i);
        src_reg_a = a;
        src_reg_b = b;
        // ready is judged before the edge that takes the instruction
        forever begin
            #1;
            ok = (insn_ready === 1'b1);
            @(posedge core_clk);
            n++;
            if (ok || n > 50) break;
        end
        chk(ok, "instruction never taken");
        @(negedge core_clk);
    endtask : issue
    task automatic idle(input int n);
        insn_valid = 1'b0;
        src_reg_a = ~src_reg_a;
        repeat (n) @(negedge core_clk);
    endtask : idle
    task automatic do_load(input logic [5:0] o, input logic [XLEN-1:0] ea, input jlm_fault_t f);
        logic [15:0] imm;
        logic [4:0] rd;
        int e0, n;
        bit al;
        imm = $random(seed);
        rd = $random(seed);
        fault_in = f;
        dly_in = $random(seed);
        w0 = wb_cnt;
        e0 = exc_cnt;
        al = (sz(o) == 2'h1 && ea[0]) || (sz(o) == 2'h2 && ea[1:0] != 0) ||
            (sz(o) == 2'h3 && ea[2:0] != 0);
        issue({o, rd, 5'h3, imm}, ea - sx(imm), {$random(seed), $random(seed)});
        idle(0);
        n = 0;
        while (wb_cnt == w0 && exc_cnt == e0 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        if (al || f != 3'h0) begin
            chk(exc_cnt == e0 + 1 && wb_cnt == w0 && exc_cause === {al, al ? 3'h0 : f} &&
                effective_addr === ea, "load exception");
        end else begin
            chk(exc_cnt == e0 && wb_cnt == w0 + 1 && wb_reg === rd, "load writeback");
            chk(mem_req_addr === ea && mem_req_size === jlm_size_t'(sz(o)), "load addr");
            chk(wb_data === ext_ld(o, last_rsp), "load data");
        end
    endtask : do_load

    initial begin
        #(40 * 30000);
        mismatches++;
        print_verdict();
    end
    initial begin
        {rstn, insn_valid, mismatches, n_checks, wb_cnt, exc_cnt, rd_cnt} = '0;
        insn = '0;
        {src_reg_a, src_reg_b, exp_acc, last_rsp} = '0;
        fault_in = '0;
        dly_in = 2'h0;
        seed = 32'h816af4d8;
        ops = '{OPC_LOAD_BYTE_S, OPC_LOAD_BYTE_Z, OPC_LOAD_HALF_S, OPC_LOAD_HALF_Z,
            OPC_LOAD_WORD_S, OPC_LOAD_WORD_Z, OPC_LOAD_DOUBLE_DFLT};
        repeat (2) @(negedge core_clk);
        rstn = 1'b1;
        chk({accum_upper_half, accum_lower_half} === ACC_RESET, "accum reset");
        for (int k = 0; k < 3; k++) begin
            t = {$random(seed), $random(seed)};
            r0 = rd_cnt;
            issue({OPC_JUMP_REG, 10'h0, 5'h4, 11'h0}, ~t, t);
            idle(3);
            chk(rd_cnt == r0, "jump before slot");
            issue({6'h15, 26'h0}, t, ~t);
            idle(4);
            chk(rd_cnt == r0 + 1 && redirect_pc === t, "jump target");
        end
        $display("test jump done");
        for (int k = 0; k < 7; k++) begin
            addr = {$random(seed), $random(seed)};
            do_load(ops[k], {addr[63:3], 3'h0}, 3'h0);
            do_load(ops[k], {addr[63:3], 3'h1}, 3'h0);
            do_load(ops[k], addr ^ 64'h6, 3'h0);
            do_load(ops[k], {addr[63:3], 3'h0}, jlm_fault_t'(3'h1 << (k % 3)));
        end
        $display("test load done");
        w0 = wb_cnt;
        r0 = exc_cnt;
        for (int k = 0; k < 10; k++) begin
            addr = {$random(seed), $random(seed)};
            t = {$random(seed), $random(seed)};
            if (k % 3 == 0) begin
                issue({OPC_MAC_IMM, t[15:11], 5'h1, 5'h0, t[10:0]}, addr, ~t);
                exp_acc = exp_acc + mac_val(addr, sx(t[15:0]));
            end else if (k == 5) begin
                issue({OPC_MAC_REG, 10'h1, 5'h2, 7'h0, 4'h2}, addr, t);
            end else begin
                issue({OPC_MAC_REG, 10'h1, 5'h2, 7'h0, MINOR_MAC}, addr, t);
                exp_acc = exp_acc + mac_val(addr, t);
            end
        end
        idle(3);
        chk({accum_upper_half, accum_lower_half} === exp_acc, "accumulate");
        chk(wb_cnt == w0 && exc_cnt == r0, "accumulate writes");
        issue({OPC_MAC_REG, 10'h1, 5'h2, 7'h0, MINOR_MAC}, t, addr);
        exp_acc = exp_acc + mac_val(t, addr);
        issue({OPC_ACC_READ_DFLT, 5'h7, 21'h0}, t, t);
        idle(3);
        chk(wb_cnt == w0 + 1 && wb_reg === 5'h7 && wb_data === exp_acc, "acc read");
        chk({accum_upper_half, accum_lower_half} === 64'h0, "acc clear");
        $display("test accumulate done");
        print_verdict();
    end
endmodule : tb_top
